// file: verilog/cex_top.sv
// Execute block for a subset of the 8-bit core instructions, APB reachable
// Functional notes
// RULE_01: Power-down zeroes watchdog counter and prescaler.
// RULE_02: Power-down clears powerdown flag, sets timeout flag.
// RULE_03: Power-down enters sleep, execution halts until wake.
// RULE_04: Literal minus W into W, updates arithmetic flags.
// RULE_05: Return pops stack into PC, no flags.
// RULE_06: Return takes two instruction cycles.
// RULE_07: Destination bit selects W or file register.
// RULE_08: Rotate right through carry, only carry changes.
// RULE_09: File minus W to destination, updates arithmetic flags.
// RULE_10: Nibble swap to destination, no flags.
// RULE_11: W xor file to destination, zero only.
// RULE_12: W xor literal into W, zero only.
// RULE_13: Carry means no borrow; digit carry likewise; zero.
`timescale 1ns/1ps
`include "cex_defs.svh"
module cex_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power state
    input wire logic wake_event,
    output logic sleep_active
);
    ////////////////////////////////////////////////////////////////////////
    cex_dp_if dp (); // Datapath carrier

    cex_file u_file (
        .pclk (pclk),
        .dp (dp.file)
    );

    cex_stack u_stack (
        .pclk (pclk),
        .presetn (presetn),
        .dp (dp.stack)
    );

    ////////////////////////////////////////////////////////////////////////
    cex_pkg::cex_state_t state_ff, nxt_state; // Sequencer
    logic [7:0] w_ff, nxt_w; // Working register
    logic c_ff, nxt_c; // Carry
    logic digit_carry_flag_ff, nxt_digit_carry_flag; // Nibble carry
    logic z_ff, nxt_z; // Zero
    logic powerdown_status_flag_ff, nxt_powerdown_status_flag; // Active low
    logic timeout_status_flag_ff, nxt_timeout_status_flag; // Active low
    logic [12:0] pc_ff, nxt_pc; // Program counter
    logic [12:0] ret_pc_ff, nxt_ret_pc; // Popped return address
    logic [6:0] faddr_ff, nxt_faddr; // Software file pointer
    logic [7:0] presc_ff, nxt_presc; // Watchdog prescaler
    logic [7:0] watchdog_counter_ff, nxt_watchdog_counter; // Watchdog count
    logic [31:0] prdata_ff, nxt_prdata; // Read data
    logic pslverr_ff, nxt_pslverr; // Error answer

    // Bus decode
    logic setup, wr_acc, exec, mapped;
    cex_pkg::cex_op_t op; // Decoded selector
    logic dest; // Destination bit
    logic [7:0] lit; // Literal operand
    logic [7:0] fv; // File operand
    logic [8:0] diff; // Subtraction with carry out
    logic [4:0] ndiff; // Low nibble subtraction
    logic [7:0] res; // Result for destination
    logic [7:0] status; // Status view

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign exec = wr_acc && paddr == `CEX_OFS_INSTR && state_ff == cex_pkg::ST_RUN;
    assign op = cex_pkg::cex_op_t'(pwdata[`CEX_OP_LSB +: 4]);
    assign dest = pwdata[`CEX_DEST_BIT];
    assign lit = pwdata[`CEX_LIT_LSB +: 8];
    assign fv = dp.f_rdata;
    assign status = {1'b0, state_ff == cex_pkg::ST_RET2, state_ff == cex_pkg::ST_SLEEP,
                     timeout_status_flag_ff, powerdown_status_flag_ff, z_ff,
                     digit_carry_flag_ff, c_ff};
    assign mapped = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Operand path: two's complement via inverted W plus one
    always_comb
    begin
        diff = 9'h000;
        ndiff = 5'h00;
        if (op == cex_pkg::OP_SUBLIT)
        begin
            diff = {1'b0, lit} + {1'b0, ~w_ff} + 9'h001; // see RULE_04
            ndiff = {1'b0, lit[3:0]} + {1'b0, ~w_ff[3:0]} + 5'h01; // see RULE_13
        end
        else
        begin
            diff = {1'b0, fv} + {1'b0, ~w_ff} + 9'h001; // see RULE_09
            ndiff = {1'b0, fv[3:0]} + {1'b0, ~w_ff[3:0]} + 5'h01; // see RULE_13
        end
    end

    // File and stack port drive
    always_comb
    begin
        res = fv;
        case (op)
            cex_pkg::OP_SUBFILE: res = diff[7:0];
            cex_pkg::OP_ROTR: res = {c_ff, fv[7:1]}; // see RULE_08
            cex_pkg::OP_SWAP: res = {fv[3:0], fv[7:4]}; // see RULE_10
            cex_pkg::OP_XORFILE: res = w_ff ^ fv; // see RULE_11
            default: res = fv;
        endcase
        dp.f_addr = faddr_ff;
        dp.f_wdata = pwdata[7:0];
        dp.f_we = wr_acc && paddr == `CEX_OFS_FDATA;
        if (exec)
        begin
            dp.f_addr = pwdata[`CEX_FADR_LSB +: 7];
            dp.f_wdata = res;
            // Destination 1 writes back to the file
            dp.f_we = dest && (op == cex_pkg::OP_SUBFILE || op == cex_pkg::OP_ROTR ||
                      op == cex_pkg::OP_SWAP || op == cex_pkg::OP_XORFILE); // see RULE_07
        end
        dp.push = wr_acc && paddr == `CEX_OFS_PUSH;
        dp.push_data = pwdata[12:0];
        dp.pop = exec && op == cex_pkg::OP_RETURN; // see RULE_05
    end

    ////////////////////////////////////////////////////////////////////////
    // Core state next values
    always_comb
    begin
        nxt_state = state_ff;
        nxt_w = w_ff;
        nxt_c = c_ff;
        nxt_digit_carry_flag = digit_carry_flag_ff;
        nxt_z = z_ff;
        nxt_powerdown_status_flag = powerdown_status_flag_ff;
        nxt_timeout_status_flag = timeout_status_flag_ff;
        nxt_pc = pc_ff;
        nxt_ret_pc = ret_pc_ff;
        nxt_faddr = faddr_ff;
        nxt_presc = presc_ff + 8'h01;
        nxt_watchdog_counter = watchdog_counter_ff;
        if (presc_ff == 8'hff)
        begin
            nxt_watchdog_counter = watchdog_counter_ff + 8'h01;
        end
        // Software register writes
        if (wr_acc)
        begin
            case (paddr)
                `CEX_OFS_WREG: nxt_w = pwdata[7:0];
                `CEX_OFS_PC: nxt_pc = pwdata[12:0];
                `CEX_OFS_FADDR: nxt_faddr = pwdata[6:0];
                `CEX_OFS_STATUS:
                begin
                    nxt_c = pwdata[`CEX_ST_C];
                    nxt_digit_carry_flag = pwdata[`CEX_ST_DIGC];
                    nxt_z = pwdata[`CEX_ST_Z];
                end
                default: nxt_w = w_ff;
            endcase
        end
        // Sequencer
        case (state_ff)
            cex_pkg::ST_RUN:
            begin
                if (exec)
                begin
                    nxt_pc = pc_ff + 13'h0001;
                    case (op)
                        cex_pkg::OP_SLEEP:
                        begin
                            nxt_watchdog_counter = `CEX_WDOG_CLR; // see RULE_01
                            nxt_presc = `CEX_PRESC_CLR; // see RULE_01
                            nxt_powerdown_status_flag = 1'b0; // see RULE_02
                            nxt_timeout_status_flag = 1'b1; // see RULE_02
                            nxt_state = cex_pkg::ST_SLEEP; // see RULE_03
                        end
                        cex_pkg::OP_RETURN:
                        begin
                            nxt_ret_pc = dp.stack_top_entry; // see RULE_05
                            nxt_pc = pc_ff;
                            nxt_state = cex_pkg::ST_RET2; // see RULE_06
                        end
                        cex_pkg::OP_SUBLIT, cex_pkg::OP_SUBFILE:
                        begin
                            if (op == cex_pkg::OP_SUBLIT || !dest)
                            begin
                                nxt_w = diff[7:0]; // see RULE_07
                            end
                            nxt_c = diff[8]; // see RULE_13
                            nxt_digit_carry_flag = ndiff[4]; // see RULE_13
                            nxt_z = diff[7:0] == 8'h00; // see RULE_13
                        end
                        cex_pkg::OP_ROTR, cex_pkg::OP_SWAP, cex_pkg::OP_XORFILE:
                        begin
                            if (!dest)
                            begin
                                nxt_w = res; // see RULE_07
                            end
                            if (op == cex_pkg::OP_ROTR)
                            begin
                                nxt_c = fv[0]; // see RULE_08
                            end
                            if (op == cex_pkg::OP_XORFILE)
                            begin
                                nxt_z = res == 8'h00; // see RULE_11
                            end
                        end
                        cex_pkg::OP_XORLIT:
                        begin
                            nxt_w = w_ff ^ lit; // see RULE_12
                            nxt_z = (w_ff ^ lit) == 8'h00; // see RULE_12
                        end
                        default: nxt_state = cex_pkg::ST_RUN;
                    endcase
                end
            end
            cex_pkg::ST_RET2:
            begin
                nxt_pc = ret_pc_ff; // see RULE_05
                nxt_state = cex_pkg::ST_RUN; // see RULE_06
            end
            cex_pkg::ST_SLEEP:
            begin
                // Stays halted until a wake event
                if (wake_event)
                begin
                    nxt_state = cex_pkg::ST_RUN; // see RULE_03
                end
            end
            default: nxt_state = cex_pkg::ST_RUN;
        endcase
    end

    // Core state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= cex_pkg::ST_RUN;
            w_ff <= `CEX_W_RST;
            c_ff <= 1'b0;
            digit_carry_flag_ff <= 1'b0;
            z_ff <= 1'b0;
            powerdown_status_flag_ff <= 1'b1;
            timeout_status_flag_ff <= 1'b1;
            pc_ff <= `CEX_PC_RST;
            ret_pc_ff <= `CEX_PC_RST;
            faddr_ff <= 7'h00;
            presc_ff <= `CEX_PRESC_CLR;
            watchdog_counter_ff <= `CEX_WDOG_CLR;
        end
        else
        begin
            state_ff <= nxt_state;
            w_ff <= nxt_w;
            c_ff <= nxt_c;
            digit_carry_flag_ff <= nxt_digit_carry_flag;
            z_ff <= nxt_z;
            powerdown_status_flag_ff <= nxt_powerdown_status_flag;
            timeout_status_flag_ff <= nxt_timeout_status_flag;
            pc_ff <= nxt_pc;
            ret_pc_ff <= nxt_ret_pc;
            faddr_ff <= nxt_faddr;
            presc_ff <= nxt_presc;
            watchdog_counter_ff <= nxt_watchdog_counter;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data captured in the setup cycle
    always_comb
    begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (setup)
        begin
            nxt_pslverr = !mapped;
            case (paddr)
                `CEX_OFS_WREG: nxt_prdata = {24'h000000, w_ff};
                `CEX_OFS_STATUS: nxt_prdata = {24'h000000, status};
                `CEX_OFS_PC: nxt_prdata = {19'h00000, pc_ff};
                `CEX_OFS_FDATA: nxt_prdata = {24'h000000, fv};
                `CEX_OFS_FADDR: nxt_prdata = {25'h0000000, faddr_ff};
                `CEX_OFS_WDOG: nxt_prdata = {16'h0000, watchdog_counter_ff, presc_ff};
                default: nxt_prdata = 32'h00000000;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = 1'b1; // No wait states
    assign pslverr = pslverr_ff && psel && penable;
    assign sleep_active = state_ff == cex_pkg::ST_SLEEP; // Oscillator gate

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ret_exec;
        exec && op == cex_pkg::OP_RETURN;
    endsequence
    sequence s_ret_done;
        state_ff == cex_pkg::ST_RET2 ##1 state_ff == cex_pkg::ST_RUN;
    endsequence

    a_sleep_wdt_clear: assert property ( // see RULE_01
        exec && op == cex_pkg::OP_SLEEP |=> watchdog_counter_ff == 8'h00 && presc_ff == 8'h00)
        else $error("watchdog not cleared by power-down");
    a_sleep_flags: assert property ( // see RULE_02
        exec && op == cex_pkg::OP_SLEEP |=> !powerdown_status_flag_ff && timeout_status_flag_ff
        && $stable(z_ff) && $stable(c_ff))
        else $error("power-down flags wrong");
    a_sleep_halt: assert property ( // see RULE_03
        sleep_active && !wake_event |=> sleep_active && $stable(pc_ff) && $stable(w_ff))
        else $error("execution during sleep");
    a_sub_lit: assert property ( // see RULE_04
        exec && op == cex_pkg::OP_SUBLIT |=> w_ff == 8'($past(lit) - $past(w_ff))
        && z_ff == (w_ff == 8'h00))
        else $error("literal subtract wrong");
    a_return_seq: assert property ( // see RULE_06
        s_ret_exec |=> s_ret_done)
        else $error("return not two cycles");
    a_return_pc: assert property ( // see RULE_05
        s_ret_exec |=> ##1 pc_ff == $past(dp.stack_top_entry, 2) && $stable(z_ff))
        else $error("return address wrong");
    a_swap_dest: assert property ( // see RULE_10
        exec && op == cex_pkg::OP_SWAP && !dest |=> w_ff == {$past(fv[3:0]), $past(fv[7:4])})
        else $error("swap into W wrong");
    a_rotr_carry: assert property ( // see RULE_08
        exec && op == cex_pkg::OP_ROTR |=> c_ff == $past(fv[0]) && $stable(z_ff))
        else $error("rotate carry wrong");
    a_sub_borrow: assert property ( // see RULE_13
        exec && op == cex_pkg::OP_SUBFILE |=> c_ff == ($past(fv) >= $past(w_ff))
        && digit_carry_flag_ff == ($past(fv[3:0]) >= $past(w_ff[3:0])))
        else $error("borrow flags wrong");
    a_xor_file: assert property ( // see RULE_11
        exec && op == cex_pkg::OP_XORFILE && !dest |=> w_ff == ($past(w_ff) ^ $past(fv)))
        else $error("file xor wrong");
    a_xor_zero: assert property ( // see RULE_12
        exec && op == cex_pkg::OP_XORLIT |=> z_ff == ($past(w_ff) == $past(lit)) && $stable(c_ff))
        else $error("literal xor zero wrong");
endmodule // cex_top

// file: pkg/cex_defs.svh
// Register offsets, field positions, reset values and counts for the execute block
`ifndef CEX_DEFS_SVH
`define CEX_DEFS_SVH
// Register byte offsets
`define CEX_OFS_INSTR 8'h00
`define CEX_OFS_WREG 8'h04
`define CEX_OFS_STATUS 8'h08
`define CEX_OFS_PC 8'h0c
`define CEX_OFS_FDATA 8'h10
`define CEX_OFS_FADDR 8'h14
`define CEX_OFS_WDOG 8'h18
`define CEX_OFS_PUSH 8'h1c
// Instruction word fields
`define CEX_OP_LSB 0
`define CEX_DEST_BIT 4
`define CEX_FADR_LSB 8
`define CEX_LIT_LSB 16
// Status bit positions
`define CEX_ST_C 0
`define CEX_ST_DIGC 1
`define CEX_ST_Z 2
`define CEX_ST_PDN 3
`define CEX_ST_TON 4
`define CEX_ST_SLEEP 5
`define CEX_ST_BUSY 6
// Reset values and counts
`define CEX_W_RST 8'h00
`define CEX_PC_RST 13'h0000
`define CEX_WDOG_CLR 8'h00
`define CEX_PRESC_CLR 8'h00
`define CEX_FILE_DEPTH 128
`define CEX_STACK_DEPTH 8
`endif

// file: pkg/cex_pkg.sv
// Types shared by the execute block modules
package cex_pkg;
    // Instruction selector written into the instruction register
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_SLEEP = 4'h1,
        OP_RETURN = 4'h2,
        OP_SUBLIT = 4'h3,
        OP_SUBFILE = 4'h4,
        OP_ROTR = 4'h5,
        OP_SWAP = 4'h6,
        OP_XORFILE = 4'h7,
        OP_XORLIT = 4'h8
    } cex_op_t;
    // Sequencer states, Gray along run, return, sleep
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_RET2 = 2'h1,
        ST_SLEEP = 2'h3
    } cex_state_t;
endpackage

// file: pkg/cex_dp_if.sv
// Datapath carrier between core, file register store and stack
`timescale 1ns/1ps
interface cex_dp_if;
    logic [6:0] f_addr; // File address
    logic [7:0] f_wdata; // File write data
    logic f_we; // File write strobe
    logic [7:0] f_rdata; // File read data
    logic push; // Stack push strobe
    logic pop; // Stack pop strobe
    logic [12:0] push_data; // Value pushed
    logic [12:0] stack_top_entry; // Current top of stack
    modport core (output f_addr, f_wdata, f_we, push, pop, push_data,
                  input f_rdata, stack_top_entry);
    modport file (input f_addr, f_wdata, f_we, output f_rdata);
    modport stack (input push, pop, push_data, output stack_top_entry);
endinterface

// file: verilog/cex_file.sv
// File register store, 128 bytes, one write and one read port
`timescale 1ns/1ps
`include "cex_defs.svh"
module cex_file (
    // Clock
    input wire logic pclk,
    // Datapath
    cex_dp_if.file dp
);
    logic [7:0] mem [`CEX_FILE_DEPTH]; // Storage, no reset by design

    // Write at the clock edge
    always_ff @(posedge pclk)
    begin
        if (dp.f_we)
        begin
            mem[dp.f_addr] <= dp.f_wdata;
        end
    end

    // Asynchronous read so execution sees the operand in its cycle
    assign dp.f_rdata = mem[dp.f_addr];
endmodule // cex_file

// file: verilog/cex_stack.sv
// Eight entry circular return stack
`timescale 1ns/1ps
`include "cex_defs.svh"
module cex_stack (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Datapath
    cex_dp_if.stack dp
);
    logic [2:0] ptr_ff; // Next free slot
    logic [2:0] nxt_ptr;
    logic [12:0] ent_ff [`CEX_STACK_DEPTH]; // Entries

    // Pointer next value, push has priority
    always_comb
    begin
        nxt_ptr = ptr_ff;
        if (dp.push)
        begin
            nxt_ptr = ptr_ff + 3'h1;
        end
        else if (dp.pop)
        begin
            nxt_ptr = ptr_ff - 3'h1;
        end
    end

    // Pointer register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ptr_ff <= 3'h0;
        end
        else
        begin
            ptr_ff <= nxt_ptr;
        end
    end

    // One register per entry, loaded on push into the free slot
    for (genvar i = 0; i < `CEX_STACK_DEPTH; i++)
    begin : g_ent
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                ent_ff[i] <= 13'h0000;
            end
            else if (dp.push && ptr_ff == 3'(i))
            begin
                ent_ff[i] <= dp.push_data;
            end
        end
    end

    // Top is the slot below the pointer
    assign dp.stack_top_entry = ent_ff[ptr_ff - 3'h1];
endmodule // cex_stack

// file: tb/test_cpu_instruction_execute_subset.sv
// Self-checking bench for the execute block, driven over APB
`timescale 1ns/1ps
`include "cex_defs.svh"
module test_cpu_instruction_execute_subset;
    ////////////////////////////////////////////////////////////////////////
    // Clock and reset
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    // APB master side
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Power state
    logic wake_event = 1'b0;
    logic sleep_active;
    // Bookkeeping
    int num_errors = 0;
    int checks_done = 0;
    logic last_err; // Error response of the latest transfer

    // Device under test
    cex_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_event(wake_event),
        .sleep_active(sleep_active)
    );

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare one value, count and report
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer: setup, then access until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        // Ready seen on every transfer, a hung slave ends the run
        chk("pready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1)
        begin
            results();
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Register write and read shorthands
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
    endtask

    // Instruction word: op, destination, file address, literal
    function automatic logic [31:0] iw(cex_pkg::cex_op_t op, logic dst,
                                       logic [6:0] fa, logic [7:0] k);
        return {8'h00, k, 1'b0, fa, 3'h0, dst, op};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Preload W, file and flags, execute, check W, file, flags and PC
    task alu(input cex_pkg::cex_op_t op, input logic dst, input logic [6:0] fa,
             input logic [7:0] k, input logic [7:0] w0, input logic [7:0] f0,
             input logic [2:0] fl0, input logic [7:0] res, input logic [2:0] fl1);
        logic [31:0] r;
        wr(`CEX_OFS_WREG, {24'h0, w0});
        wr(`CEX_OFS_FADDR, {25'h0, fa});
        wr(`CEX_OFS_FDATA, {24'h0, f0});
        wr(`CEX_OFS_STATUS, {29'h0, fl0});
        wr(`CEX_OFS_PC, 32'h00000100);
        wr(`CEX_OFS_INSTR, iw(op, dst, fa, k));
        rd(`CEX_OFS_WREG, r);
        chk("wreg", {24'h0, dst ? w0 : res}, r);
        rd(`CEX_OFS_FDATA, r);
        chk("file", {24'h0, dst ? res : f0}, r);
        rd(`CEX_OFS_STATUS, r);
        chk("flags", {29'h0, fl1}, {29'h0, r[2:0]});
        rd(`CEX_OFS_PC, r);
        chk("pc", 32'h00000101, r);
    endtask

    // Values after reset
    task sc_reset;
        logic [31:0] r;
        chk("sleep", 32'h0, {31'h0, sleep_active});
        rd(`CEX_OFS_STATUS, r);
        chk("status", 32'h00000018, r);
        rd(`CEX_OFS_WREG, r);
        chk("wreg", 32'h0, r);
        rd(`CEX_OFS_PC, r);
        chk("pc", 32'h0, r);
    endtask

    // Both subtractions, with and without borrow
    task sc_subtract;
        alu(cex_pkg::OP_SUBLIT, 1'b0, 7'h00, 8'h03, 8'h05, 8'h00, 3'b111, 8'hfe, 3'b000);
        alu(cex_pkg::OP_SUBLIT, 1'b0, 7'h00, 8'h05, 8'h05, 8'h00, 3'b000, 8'h00, 3'b111);
        alu(cex_pkg::OP_SUBFILE, 1'b1, 7'h7f, 8'h00, 8'h01, 8'h10, 3'b000, 8'h0f, 3'b001);
        alu(cex_pkg::OP_SUBFILE, 1'b0, 7'h00, 8'h00, 8'h21, 8'h20, 3'b111, 8'hff, 3'b000);
    endtask

    // Rotate through carry, swap and both exclusive-ORs
    task sc_logic;
        alu(cex_pkg::OP_ROTR, 1'b1, 7'h11, 8'h00, 8'h77, 8'h01, 3'b010, 8'h00, 3'b011);
        alu(cex_pkg::OP_ROTR, 1'b0, 7'h12, 8'h00, 8'h77, 8'h80, 3'b101, 8'hc0, 3'b100);
        alu(cex_pkg::OP_SWAP, 1'b0, 7'h13, 8'h00, 8'h00, 8'ha5, 3'b111, 8'h5a, 3'b111);
        alu(cex_pkg::OP_SWAP, 1'b1, 7'h14, 8'h00, 8'h00, 8'h3c, 3'b000, 8'hc3, 3'b000);
        alu(cex_pkg::OP_XORFILE, 1'b1, 7'h15, 8'h00, 8'h5a, 8'h5a, 3'b011, 8'h00, 3'b111);
        alu(cex_pkg::OP_XORFILE, 1'b0, 7'h16, 8'h00, 8'h0f, 8'h3c, 3'b100, 8'h33, 3'b000);
        alu(cex_pkg::OP_XORLIT, 1'b0, 7'h00, 8'hf0, 8'h0f, 8'h00, 3'b100, 8'hff, 3'b000);
    endtask

    // Two nested returns pop in reverse order, flags kept
    task sc_return;
        logic [31:0] r;
        wr(`CEX_OFS_PUSH, 32'h00000123);
        wr(`CEX_OFS_PUSH, 32'h00000456);
        wr(`CEX_OFS_STATUS, 32'h00000005);
        wr(`CEX_OFS_INSTR, iw(cex_pkg::OP_RETURN, 1'b0, 7'h00, 8'h00));
        rd(`CEX_OFS_PC, r);
        chk("pc", 32'h00000456, r);
        wr(`CEX_OFS_INSTR, iw(cex_pkg::OP_RETURN, 1'b0, 7'h00, 8'h00));
        rd(`CEX_OFS_PC, r);
        chk("pc", 32'h00000123, r);
        rd(`CEX_OFS_STATUS, r);
        chk("flags", 32'h5, {29'h0, r[2:0]});
    endtask

    // Wait a bounded time for the sleep output to reach a level
    task wait_sleep(input logic lvl);
        int n;
        n = 0;
        while (sleep_active !== lvl && n < 8)
        begin
            @(posedge pclk);
            n++;
        end
        chk("sleep", {31'h0, lvl}, {31'h0, sleep_active});
        // Exhausted wait goes straight to the report
        if (sleep_active !== lvl)
        begin
            results();
        end
    endtask

    // Power-down: watchdog cleared, flags, halt, ignored work, wake
    task sc_sleep;
        logic [31:0] r;
        repeat (600) @(posedge pclk);
        wr(`CEX_OFS_WREG, 32'h0000003c);
        wr(`CEX_OFS_STATUS, 32'h00000005);
        wr(`CEX_OFS_INSTR, iw(cex_pkg::OP_SLEEP, 1'b0, 7'h00, 8'h00));
        wait_sleep(1'b1);
        rd(`CEX_OFS_WDOG, r);
        chk("watchdog count", 32'h0, {24'h0, r[15:8]});
        rd(`CEX_OFS_STATUS, r);
        chk("status", 32'h00000035, r);
        wr(`CEX_OFS_INSTR, iw(cex_pkg::OP_XORLIT, 1'b0, 7'h00, 8'hff));
        rd(`CEX_OFS_WREG, r);
        chk("wreg", 32'h0000003c, r);
        @(posedge pclk);
        wake_event <= 1'b1;
        @(posedge pclk);
        wake_event <= 1'b0;
        wait_sleep(1'b0);
        wr(`CEX_OFS_INSTR, iw(cex_pkg::OP_XORLIT, 1'b0, 7'h00, 8'hff));
        rd(`CEX_OFS_WREG, r);
        chk("wreg", 32'h000000c3, r);
    endtask

    // Unmapped and misaligned addresses answer with an error
    task sc_unmapped;
        logic [31:0] r;
        rd(8'h20, r);
        chk("unmapped data", 32'h0, r);
        chk("unmapped err", 32'h1, {31'h0, last_err});
        wr(8'h06, 32'h000000ff);
        chk("misaligned err", 32'h1, {31'h0, last_err});
        rd(`CEX_OFS_WREG, r);
        chk("mapped err", 32'h0, {31'h0, last_err});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        sc_reset();
        sc_subtract();
        sc_logic();
        sc_return();
        sc_sleep();
        sc_unmapped();
        results();
    end
endmodule // test_cpu_instruction_execute_subset
